// >>> hdl/uil_core.sv
// Interrupt enable, priority, status and clearing logic for one UART channel
//
// Functional notes
// - With FIFO on and rx enabled, rx data interrupt follows fill versus trigger.
// - Line status bit 0 set on character into FIFO, cleared when FIFO empty.
// - FIFO on with mask bits 0-3 clear gives polled operation via line status.
// - Line status bits: 1 overrun, 2-4 head error, 5/6 tx empties, 7 fifo error.
// - Mask bit 0 enables rx data interrupt: holding full, or trigger in FIFO mode.
// - Mask bit 1 enables tx ready; fires at once if tx already empty.
// - Mask bit 2: overrun interrupts on arrival, other errors as the character reaches the FIFO head.
// - Mask bit 3: modem delta bits 0-3 raise modem interrupt.
// - Mask bits 4-7 act only with feature bit 4; bit 4 sleep, 5 pause.
// - Mask bit 6: RTS rising interrupts; bit 7: CTS rising interrupts.
// - RTS/CTS change interrupts only while auto flow control is on.
// - Source read returns top pending; a newly pending higher source replaces it on the next edge.
// - Rx time-out after four chars plus twelve bits idle with data held.
// - Tx ready cleared by source read or tx holding write.
// - Line status read clears line interrupt; modem interrupt clears when modem delta bits 0-3 return to 0.
// - Rx data clears when fill drops; time-out clears on holding read.
// - Pause char sets interrupt; source read or resume char clears it.
// - Special char sets interrupt; source read or next character clears it.
// - Modem status read clears RTS/CTS change interrupts.
// - Wake-up indication posted on leaving sleep, cleared by source read.
// - Feature bit 4 gates enhanced fields of other registers.
// - Key in line control maps feature and flow-char registers over standard ones.
// - Source bit 0 reads 0 while pending, 1 otherwise or after wake.
`timescale 1ns/1ps
`default_nettype none

module uil_core
	import uil_pkg::*;
#(
	parameter int TIMER_W = 10
) (
	input  wire logic     clk_in,
	input  wire logic     rstn_in,
	input  wire uil_bus_t bus_in,
	input  wire uil_evt_t evt_in,
	input  wire logic     sleep_exit_in,
	output logic [7:0]    rd_data_out,
	output logic          irq_out,
	output logic [7:0]    feature_out,
	output logic [7:0]    mask_out,
	output logic [7:0]    line_control_out,
	output logic [7:0]    resume_1_out,
	output logic [7:0]    resume_2_out,
	output logic [7:0]    pause_1_out,
	output logic [7:0]    pause_2_out
);

	typedef enum logic [1:0] {
		UIL_IDLE = 2'b01,
		UIL_HELD = 2'b10
	} uil_state_t;

	logic [7:0]  mask_ff;
	logic [7:0]  feature_ff;
	logic [7:0]  lcr_ff;
	logic [7:0]  resume_1_ff;
	logic [7:0]  resume_2_ff;
	logic [7:0]  pause_1_ff;
	logic [7:0]  pause_2_ff;
	logic        tx_pend_ff;
	logic        line_err_ff;
	logic        timeout_ff;
	logic        pause_ff;
	logic        special_ff;
	logic        flow_ff;
	logic        wake_ff;
	logic        rts_d_ff;
	logic        cts_d_ff;
	logic        tx_empty_d_ff;
	logic        tx_en_d_ff;
	logic [TIMER_W-1:0] idle_ff;
	logic [5:0]  held_src_ff;
	uil_state_t  state_ff;
	logic [7:0]  rd_data_ff;
	logic        irq_ff;

	logic        enh_bank;
	logic        enh_on;
	logic        rd_src;
	logic        rd_lsr;
	logic        rd_msr;
	logic        rd_rhr;
	logic        wr_thr;
	logic        rx_data_pend;
	logic        modem_pend;
	logic [TIMER_W-1:0] idle_limit;
	logic [5:0]  nxt_src;
	logic [7:0]  line_status;
	logic [7:0]  nxt_rd;
	logic        rts_rise;
	logic        cts_rise;
	logic        tx_rise;
	logic        pend_any;

	// Access decode; bank key swaps in the enhanced registers
	assign enh_bank = (lcr_ff == ENH_ACCESS_KEY);
	assign enh_on   = feature_ff[FEAT_ENH_BIT];
	assign rd_src   = bus_in.rd && !enh_bank && !lcr_ff[7] && bus_in.addr == ADDR_SOURCE;
	assign rd_lsr   = bus_in.rd && !enh_bank && bus_in.addr == ADDR_LINE_STATUS;
	assign rd_msr   = bus_in.rd && !enh_bank && bus_in.addr == ADDR_MODEM_STATUS;
	assign rd_rhr   = bus_in.rd && !lcr_ff[7] && bus_in.addr == ADDR_HOLDING;
	assign wr_thr   = bus_in.wr && !lcr_ff[7] && bus_in.addr == ADDR_HOLDING;

	// Line status assembled from the receive and transmit sides
	assign line_status = {evt_in.fifo_err, evt_in.tx_all_empty, evt_in.tx_empty,
		evt_in.head_err, evt_in.rx_overrun, (evt_in.rx_count != 5'h00)};

	// Rx data: trigger level with FIFO on, any character otherwise
	assign rx_data_pend = mask_ff[MASK_RX_DATA] && (evt_in.fifo_en ?
		(evt_in.rx_count >= evt_in.rx_trigger) : (evt_in.rx_count != 5'h00));

	assign modem_pend = mask_ff[MASK_MODEM] && (evt_in.modem_delta != 4'h0);

	// Time-out limit in bit times: four characters plus twelve bits
	assign idle_limit = TIMER_W'(TIMEOUT_CHARS) * TIMER_W'(evt_in.char_bits) + TIMER_W'(TIMEOUT_BITS);

	assign rts_rise = evt_in.rts_pin && !rts_d_ff;
	assign cts_rise = evt_in.cts_pin && !cts_d_ff;
	assign tx_rise  = evt_in.tx_below_trig && !tx_empty_d_ff;

	// Highest pending source picks the code
	always_comb begin
		if (line_err_ff && mask_ff[MASK_LINE]) begin
			nxt_src = SRC_LINE;
		end else if (timeout_ff && mask_ff[MASK_RX_DATA]) begin
			nxt_src = SRC_TIMEOUT;
		end else if (rx_data_pend) begin
			nxt_src = SRC_RX_DATA;
		end else if (tx_pend_ff) begin
			nxt_src = SRC_TX;
		end else if (modem_pend) begin
			nxt_src = SRC_MODEM;
		end else if ((pause_ff || special_ff) && enh_on && mask_ff[MASK_PAUSE]) begin
			nxt_src = SRC_PAUSE;
		end else if (flow_ff && enh_on) begin
			nxt_src = SRC_FLOW;
		end else begin
			nxt_src = SRC_NONE;
		end
	end

	assign pend_any = (nxt_src != SRC_NONE);

	// Control registers written by the host
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mask_ff     <= MASK_RESET;
			feature_ff  <= FEATURE_RESET;
			lcr_ff      <= 8'h00;
			resume_1_ff <= CHAR_RESET;
			resume_2_ff <= CHAR_RESET;
			pause_1_ff  <= CHAR_RESET;
			pause_2_ff  <= CHAR_RESET;
		end else if (bus_in.wr) begin
			if (bus_in.addr == ADDR_LINE_CONTROL) begin
				lcr_ff <= bus_in.data;
			end else if (enh_bank) begin
				case (bus_in.addr)
					ADDR_FEATURE:  feature_ff  <= bus_in.data;
					ADDR_RESUME_1: resume_1_ff <= bus_in.data;
					ADDR_RESUME_2: resume_2_ff <= bus_in.data;
					ADDR_PAUSE_1:  pause_1_ff  <= bus_in.data;
					ADDR_PAUSE_2:  pause_2_ff  <= bus_in.data;
					default: begin
					end
				endcase
			end else if (!lcr_ff[7] && bus_in.addr == ADDR_MASK) begin
				// Upper bits held unchanged unless enhanced mode is on
				mask_ff <= enh_on ? bus_in.data : {mask_ff[7:4], bus_in.data[3:0]};
			end
		end
	end

	// Tx ready: edge of empty or enable rising while empty; set wins over clear
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_pend_ff    <= 1'b0;
			tx_empty_d_ff <= 1'b0;
			tx_en_d_ff    <= 1'b0;
		end else begin
			tx_empty_d_ff <= evt_in.tx_below_trig;
			tx_en_d_ff    <= mask_ff[MASK_TX_READY];
			if (mask_ff[MASK_TX_READY] && evt_in.tx_below_trig && (tx_rise || !tx_en_d_ff)) begin
				tx_pend_ff <= 1'b1;
			end else if (!mask_ff[MASK_TX_READY] || wr_thr || (rd_src && held_src_ff == SRC_TX)) begin
				tx_pend_ff <= 1'b0;
			end
		end
	end

	// Line errors: overrun on arrival, others as head reaches holding position
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			line_err_ff <= 1'b0;
		end else if (evt_in.rx_overrun || evt_in.head_err != 3'h0) begin
			line_err_ff <= 1'b1;
		end else if (rd_lsr) begin
			line_err_ff <= 1'b0;
		end
	end

	// Receive idle timer counted in bit ticks while data is held
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			idle_ff    <= '0;
			timeout_ff <= 1'b0;
		end else begin
			if (evt_in.rx_push || rd_rhr || evt_in.rx_count == 5'h00) begin
				idle_ff <= '0;
			end else if (evt_in.bit_tick && idle_ff != idle_limit) begin
				idle_ff <= idle_ff + 1'b1;
			end
			if (evt_in.fifo_en && evt_in.rx_count != 5'h00 && idle_ff == idle_limit
				&& !rd_rhr) begin
				timeout_ff <= 1'b1;
			end else if (rd_rhr || evt_in.rx_count == 5'h00) begin
				timeout_ff <= 1'b0;
			end
		end
	end

	// Pause and special character flags
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pause_ff   <= 1'b0;
			special_ff <= 1'b0;
		end else begin
			if (evt_in.pause_seen) begin
				pause_ff <= 1'b1;
			end else if (evt_in.resume_seen || (rd_src && held_src_ff == SRC_PAUSE)) begin
				pause_ff <= 1'b0;
			end
			if (evt_in.special_seen && evt_in.special_sel) begin
				special_ff <= 1'b1;
			end else if (evt_in.rx_push || (rd_src && held_src_ff == SRC_PAUSE)) begin
				special_ff <= 1'b0;
			end
		end
	end

	// Flow-control change on rising RTS/CTS under automatic flow control
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			flow_ff  <= 1'b0;
			rts_d_ff <= 1'b0;
			cts_d_ff <= 1'b0;
		end else begin
			rts_d_ff <= evt_in.rts_pin;
			cts_d_ff <= evt_in.cts_pin;
			if ((rts_rise && mask_ff[MASK_RTS] && feature_ff[FEAT_AUTO_RTS]) ||
				(cts_rise && mask_ff[MASK_CTS] && feature_ff[FEAT_AUTO_CTS])) begin
				flow_ff <= 1'b1;
			end else if (rd_msr) begin
				flow_ff <= 1'b0;
			end
		end
	end

	// Wake-up indication; shows as "no interrupt" in the source code
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wake_ff <= 1'b0;
		end else if (sleep_exit_in) begin
			wake_ff <= 1'b1;
		end else if (rd_src) begin
			wake_ff <= 1'b0;
		end
	end

	// Held source: code follows the top pending source one edge later
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_ff    <= UIL_IDLE;
			held_src_ff <= SRC_NONE;
		end else begin
			case (state_ff)
				UIL_IDLE: begin
					held_src_ff <= nxt_src;
					if (pend_any) begin
						state_ff <= UIL_HELD;
					end
				end
				UIL_HELD: begin
					// Lower sources wait; a higher one replaces this code on the next edge
					if (nxt_src != held_src_ff) begin
						held_src_ff <= nxt_src;
						state_ff    <= pend_any ? UIL_HELD : UIL_IDLE;
					end
				end
				default: begin
					state_ff    <= UIL_IDLE;
					held_src_ff <= SRC_NONE;
				end
			endcase
		end
	end

	// Read data mux
	always_comb begin
		nxt_rd = 8'h00;
		if (enh_bank && bus_in.addr != ADDR_LINE_CONTROL) begin
			case (bus_in.addr)
				ADDR_FEATURE:  nxt_rd = feature_ff;
				ADDR_RESUME_1: nxt_rd = resume_1_ff;
				ADDR_RESUME_2: nxt_rd = resume_2_ff;
				ADDR_PAUSE_1:  nxt_rd = pause_1_ff;
				ADDR_PAUSE_2:  nxt_rd = pause_2_ff;
				default:       nxt_rd = 8'h00;
			endcase
		end else begin
			case (bus_in.addr)
				ADDR_MASK:         nxt_rd = enh_on ? mask_ff : {4'h0, mask_ff[3:0]};
				ADDR_SOURCE:       nxt_rd = {{2{evt_in.fifo_en}},
					enh_on ? held_src_ff[5:4] : 2'b00, held_src_ff[3:0]};
				ADDR_LINE_CONTROL: nxt_rd = lcr_ff;
				ADDR_LINE_STATUS:  nxt_rd = line_status;
				ADDR_MODEM_STATUS: nxt_rd = {evt_in.modem_lines, evt_in.modem_delta};
				default:           nxt_rd = 8'h00;
			endcase
		end
	end

	// Registered outputs; the interrupt line follows the pending sources
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rd_data_ff <= 8'h00;
			irq_ff     <= 1'b0;
		end else begin
			rd_data_ff <= nxt_rd;
			// Wake-up also raises the line, but its source code still reads as none
			irq_ff     <= pend_any || wake_ff;
		end
	end

	assign rd_data_out      = rd_data_ff;
	assign irq_out          = irq_ff;
	assign feature_out      = feature_ff;
	assign mask_out         = mask_ff;
	assign line_control_out = lcr_ff;
	assign resume_1_out     = resume_1_ff;
	assign resume_2_out     = resume_2_ff;
	assign pause_1_out      = pause_1_ff;
	assign pause_2_out      = pause_2_ff;

endmodule : uil_core

`default_nettype wire

// >>> hdl/uil_pkg.sv
// Package for the UART interrupt logic: register map, fields, reset values and carriers
package uil_pkg;

	// Register addresses (A2-A0)
	localparam logic [2:0] ADDR_HOLDING      = 3'h0;
	localparam logic [2:0] ADDR_MASK         = 3'h1;
	localparam logic [2:0] ADDR_SOURCE       = 3'h2;
	localparam logic [2:0] ADDR_LINE_CONTROL = 3'h3;
	localparam logic [2:0] ADDR_LINE_STATUS  = 3'h5;
	localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
	localparam logic [2:0] ADDR_FEATURE      = 3'h2;
	localparam logic [2:0] ADDR_RESUME_1     = 3'h4;
	localparam logic [2:0] ADDR_RESUME_2     = 3'h5;
	localparam logic [2:0] ADDR_PAUSE_1      = 3'h6;
	localparam logic [2:0] ADDR_PAUSE_2      = 3'h7;

	// Key in line_control that opens the enhanced bank
	localparam logic [7:0] ENH_ACCESS_KEY    = 8'hbf;

	// Field positions
	localparam int FEAT_ENH_BIT     = 4;
	localparam int FEAT_AUTO_RTS    = 6;
	localparam int FEAT_AUTO_CTS    = 7;
	localparam int MASK_RX_DATA     = 0;
	localparam int MASK_TX_READY    = 1;
	localparam int MASK_LINE        = 2;
	localparam int MASK_MODEM       = 3;
	localparam int MASK_SLEEP       = 4;
	localparam int MASK_PAUSE       = 5;
	localparam int MASK_RTS         = 6;
	localparam int MASK_CTS         = 7;

	// Reset values
	localparam logic [7:0] MASK_RESET    = 8'h00;
	localparam logic [7:0] FEATURE_RESET = 8'h00;
	localparam logic [7:0] CHAR_RESET    = 8'h00;
	localparam logic [7:0] SOURCE_RESET  = 8'h01;

	// Source codes, bits 5:0 of interrupt_source
	localparam logic [5:0] SRC_LINE    = 6'h06;
	localparam logic [5:0] SRC_TIMEOUT = 6'h0c;
	localparam logic [5:0] SRC_RX_DATA = 6'h04;
	localparam logic [5:0] SRC_TX      = 6'h02;
	localparam logic [5:0] SRC_MODEM   = 6'h00;
	localparam logic [5:0] SRC_PAUSE   = 6'h10;
	localparam logic [5:0] SRC_FLOW    = 6'h20;
	localparam logic [5:0] SRC_NONE    = 6'h01;

	// Receive time-out: four characters plus twelve bits
	localparam int TIMEOUT_CHARS = 4;
	localparam int TIMEOUT_BITS  = 12;

	// Host bus request
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [2:0] addr;
		logic [7:0] data;
	} uil_bus_t;

	// Events and levels from the receiver, transmitter, FIFOs and modem side
	typedef struct packed {
		logic       fifo_en;
		logic [4:0] rx_count;
		logic [4:0] rx_trigger;
		logic       rx_push;
		logic       rx_overrun;
		logic [2:0] head_err;
		logic       fifo_err;
		logic       tx_below_trig;
		logic       tx_empty;
		logic       tx_all_empty;
		logic       bit_tick;
		logic [3:0] char_bits;
		logic [3:0] modem_delta;
		logic [3:0] modem_lines;
		logic       pause_seen;
		logic       resume_seen;
		logic       special_seen;
		logic       special_sel;
		logic       rts_pin;
		logic       cts_pin;
		logic       wake;
	} uil_evt_t;

endpackage : uil_pkg

// >>> verif/tb_uart_interrupt_logic.sv
// Self-checking bench for the UART interrupt logic
`timescale 1ns/1ps
`default_nettype none

module tb_uart_interrupt_logic;
	import uil_pkg::*;

	logic       clk_in = 1'b0;
	logic       rstn_in;
	logic       sleep_exit;
	uil_evt_t   evt;
	uil_bus_t   bus;
	logic [7:0] rd_data;
	logic [7:0] d;
	int         failures = 0;
	int         samples_checked = 0;

	// Rows: line control, address, write data, expected readback
	logic [31:0] rows [8] = '{32'hbf021010, 32'hbf04a5a5, 32'hbf055a5a, 32'hbf063c3c,
		32'hbf07c3c3, 32'h0001ffff, 32'hbf020000, 32'h0001ff0f};

	// 50 MHz clock
	always #10 clk_in = ~clk_in;

	uil_host_model host (.clk_in(clk_in), .rd_data_in(rd_data), .bus_out(bus));

	uil_core dut (.clk_in(clk_in), .rstn_in(rstn_in), .bus_in(bus), .evt_in(evt),
		.sleep_exit_in(sleep_exit), .rd_data_out(rd_data), .irq_out(), .feature_out(),
		.mask_out(), .line_control_out(), .resume_1_out(), .resume_2_out(), .pause_1_out(),
		.pause_2_out());

	// Compare one byte and count it
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// Single exit point for normal end and hang
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop

	// Watchdog sized well past the fewer than two hundred cycles the tests need
	initial begin
		repeat (3000) @(posedge clk_in);
		failures++;
		report_and_stop();
	end

	// Main sequence; event inputs change only at falling edges
	initial begin
		rstn_in = 1'b0;
		sleep_exit = 1'b0;
		evt = '0;
		repeat (5) @(negedge clk_in);
		rstn_in = 1'b1;
		host.read(ADDR_SOURCE, d);
		check(d, SOURCE_RESET);
		host.read(ADDR_MASK, d);
		check(d, MASK_RESET);
		$display("test reset done");
		foreach (rows[i]) begin
			host.write(ADDR_LINE_CONTROL, rows[i][31:24]);
			host.write(rows[i][18:16], rows[i][15:8]);
			host.read(rows[i][18:16], d);
			check(d, rows[i][7:0]);
		end
		$display("test registers done");
		// Line beats modem; overrun is a single-cycle arrival event
		evt.modem_delta = 4'h1;
		evt.rx_overrun = 1'b1;
		@(negedge clk_in);
		evt.rx_overrun = 1'b0;
		repeat (2) @(negedge clk_in);
		check({7'h00, dut.irq_out}, 8'h01);
		host.read(ADDR_SOURCE, d);
		check(d, {2'h0, SRC_LINE});
		host.read(ADDR_LINE_STATUS, d);
		host.read(ADDR_SOURCE, d);
		check(d, {2'h0, SRC_MODEM});
		evt.modem_delta = 4'h0;
		repeat (2) @(negedge clk_in);
		host.read(ADDR_SOURCE, d);
		check(d, {2'h0, SRC_NONE});
		$display("test priority done");
		// Enabling tx ready with the holding register already empty
		host.write(ADDR_MASK, 8'h00);
		evt.tx_below_trig = 1'b1;
		host.write(ADDR_MASK, 8'h02);
		repeat (2) @(negedge clk_in);
		check({7'h00, dut.irq_out}, 8'h01);
		host.read(ADDR_SOURCE, d);
		check(d, {2'h0, SRC_TX});
		host.read(ADDR_SOURCE, d);
		check(d, {2'h0, SRC_NONE});
		$display("test tx ready done");
		// Time-out at 4 chars of 8 bits plus 12 bits, i.e. 44 ticks
		evt.tx_below_trig = 1'b0;
		host.write(ADDR_MASK, 8'h01);
		evt.fifo_en = 1'b1;
		evt.rx_trigger = 5'h04;
		evt.rx_count = 5'h01;
		evt.char_bits = 4'h8;
		evt.tx_empty = 1'b1;
		evt.tx_all_empty = 1'b1;
		evt.bit_tick = 1'b1;
		repeat (36) @(negedge clk_in);
		host.read(ADDR_SOURCE, d);
		check(d, {2'h3, SRC_NONE});
		repeat (20) @(negedge clk_in);
		evt.bit_tick = 1'b0;
		host.read(ADDR_SOURCE, d);
		check(d, {2'h3, SRC_TIMEOUT});
		host.read(ADDR_HOLDING, d);
		host.read(ADDR_SOURCE, d);
		check(d, {2'h3, SRC_NONE});
		evt.rx_count = 5'h04;
		repeat (2) @(negedge clk_in);
		host.read(ADDR_SOURCE, d);
		check(d, {2'h3, SRC_RX_DATA});
		host.read(ADDR_LINE_STATUS, d);
		check(d & 8'he1, 8'h61);
		evt.rx_count = 5'h03;
		repeat (2) @(negedge clk_in);
		host.read(ADDR_SOURCE, d);
		check(d, {2'h3, SRC_NONE});
		$display("test receive done");
		// Wake-up pulse: line rises, source shows none, source read drops it
		sleep_exit = 1'b1;
		@(negedge clk_in);
		sleep_exit = 1'b0;
		@(negedge clk_in);
		check({7'h00, dut.irq_out}, 8'h01);
		host.read(ADDR_SOURCE, d);
		check(d, {2'h3, SRC_NONE});
		@(negedge clk_in);
		check({7'h00, dut.irq_out}, 8'h00);
		$display("test wake done");
		report_and_stop();
	end
endmodule : tb_uart_interrupt_logic

bind uil_core uil_core_properties #(.TIMER_W(TIMER_W)) chk (.clk_in(clk_in), .rstn_in(rstn_in),
	.bus_in(bus_in), .evt_in(evt_in), .rd_data_out(rd_data_out), .irq_out(irq_out),
	.feature_out(feature_out), .mask_out(mask_out), .line_control_out(line_control_out),
	.resume_1_out(resume_1_out), .pause_2_out(pause_2_out));

`default_nettype wire

// >>> verif/uil_core_properties.sv
// Concurrent checks on the interrupt logic ports
`timescale 1ns/1ps
`default_nettype none

module uil_core_properties
	import uil_pkg::*;
#(
	parameter int TIMER_W = 10
) (
	input wire logic       clk_in,
	input wire logic       rstn_in,
	input wire uil_bus_t   bus_in,
	input wire uil_evt_t   evt_in,
	input wire logic [7:0] rd_data_out,
	input wire logic       irq_out,
	input wire logic [7:0] feature_out,
	input wire logic [7:0] mask_out,
	input wire logic [7:0] line_control_out,
	input wire logic [7:0] resume_1_out,
	input wire logic [7:0] pause_2_out
);
	// All checks share the core clock and reset
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	// Register writes land one edge after the strobe
	lcr_write_a: assert property (
		bus_in.wr && bus_in.addr == ADDR_LINE_CONTROL |=> line_control_out == $past(bus_in.data))
		else $error("line control write lost");
	feat_write_a: assert property (
		bus_in.wr && bus_in.addr == ADDR_FEATURE && line_control_out == ENH_ACCESS_KEY
		|=> feature_out == $past(bus_in.data)) else $error("feature write lost");
	resume_write_a: assert property (
		bus_in.wr && bus_in.addr == ADDR_RESUME_1 && line_control_out == ENH_ACCESS_KEY
		|=> resume_1_out == $past(bus_in.data)) else $error("resume char write lost");
	pause_write_a: assert property (
		bus_in.wr && bus_in.addr == ADDR_PAUSE_2 && line_control_out == ENH_ACCESS_KEY
		|=> pause_2_out == $past(bus_in.data)) else $error("pause char write lost");
	mask_low_a: assert property (
		bus_in.wr && bus_in.addr == ADDR_MASK && line_control_out[7] == 1'b0
		|=> mask_out[3:0] == $past(bus_in.data[3:0])) else $error("mask low bits not written");

	// Enhanced mask bits are frozen while feature bit 4 (enhanced mode) is off
	mask_gate_a: assert property (
		!feature_out[FEAT_ENH_BIT] && $stable(feature_out) |=> $stable(mask_out[7:4]))
		else $error("enhanced mask bits changed while gated");

	// Interrupt line tracks enabled sources
	irq_quiet_a: assert property (
		mask_out == 8'h00 [*2] |-> !irq_out) else $error("interrupt with all sources masked");
	overrun_irq_a: assert property (
		mask_out[MASK_LINE] && $rose(evt_in.rx_overrun) && !bus_in.rd |-> ##[1:3] irq_out)
		else $error("overrun did not interrupt");
	tx_at_once_a: assert property (
		$rose(mask_out[MASK_TX_READY]) && evt_in.tx_below_trig && !bus_in.rd |-> ##[1:2] irq_out)
		else $error("tx ready enable on empty holding did not interrupt");
	modem_irq_a: assert property (
		(mask_out[MASK_MODEM] && evt_in.modem_delta != 4'h0) [*2] |-> irq_out)
		else $error("modem delta did not interrupt");

	// Line status read returns the transmitter empties
	lsr_tx_a: assert property (
		bus_in.rd && bus_in.addr == ADDR_LINE_STATUS && line_control_out != ENH_ACCESS_KEY
		|=> rd_data_out[6:5] == $past({evt_in.tx_all_empty, evt_in.tx_empty}))
		else $error("line status tx bits wrong");
endmodule : uil_core_properties

`default_nettype wire

// >>> verif/uil_host_model.sv
// Host processor model that drives the parallel register bus
`timescale 1ns/1ps
`default_nettype none

module uil_host_model
	import uil_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic [7:0] rd_data_in,
	output var  uil_bus_t   bus_out
);
	// Bus starts idle so no strobe is seen before reset releases
	initial begin
		bus_out = '0;
	end

	// One-cycle write strobe; data is inverted afterwards so stale bytes never look valid
	task automatic write(input logic [2:0] addr, input logic [7:0] data);
		@(negedge clk_in);
		bus_out.wr   = 1'b1;
		bus_out.addr = addr;
		bus_out.data = data;
		@(negedge clk_in);
		bus_out.wr   = 1'b0;
		bus_out.data = ~data;
	endtask : write

	// One-cycle read strobe; address is held so the answer stays on the bus
	task automatic read(input logic [2:0] addr, output logic [7:0] data);
		@(negedge clk_in);
		bus_out.rd   = 1'b1;
		bus_out.addr = addr;
		@(negedge clk_in);
		bus_out.rd   = 1'b0;
		data         = rd_data_in;
	endtask : read
endmodule : uil_host_model

`default_nettype wire
